// File: ubg_params.svh
// constants of the usart rate generator: register indices, reset values, divider ratios
// assumes inclusion by bare name from the package and the design modules
`ifndef UBG_PARAMS_SVH
`define UBG_PARAMS_SVH

// register indices; byte address is four times the index
`define UBG_IDX_RX_CTRL  8'h18
`define UBG_IDX_TX_CTRL  8'h98
`define UBG_IDX_DIVISOR  8'h99

// reset values
`define UBG_TX_CTRL_RST  8'h02
`define UBG_RX_CTRL_RST  8'h00
`define UBG_DIVISOR_RST  8'h00

// divider chain ratios
`define UBG_PRESCALE     5'h04
`define UBG_POST_LOW     5'h10
`define UBG_POST_HIGH    5'h04
`define UBG_POST_SYNC    5'h01

`endif

// File: ubg_pkg.sv
// types and helpers shared by the rate generator modules
// assumes the constants header sits in the same folder
`include "ubg_params.svh"

package ubg_pkg;

  // rate mode, one-hot
  typedef enum logic [2:0] {
    UBG_ASYNC_LOW  = 3'h1,
    UBG_ASYNC_HIGH = 3'h2,
    UBG_SYNC       = 3'h4
  } ubg_rate_mode_t;

  // transmit status and control fields, bit 7 first
  typedef struct packed {
    logic clock_source_select;
    logic transmit_nine_bit;
    logic transmit_enable_bit;
    logic sync_mode;
    logic unused3;
    logic high_speed_select;
    logic shift_register_empty;
    logic transmit_ninth_bit;
  } ubg_tx_ctrl_t;

  // receive status and control fields, bit 7 first
  typedef struct packed {
    logic port_enable;
    logic receive_nine_bit;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic received_ninth_bit;
  } ubg_rx_ctrl_t;

  // mode from sync and high speed select; high speed ignored in sync
  function automatic ubg_rate_mode_t ubg_mode(input logic sync, input logic hs);
    if (sync) begin
      return UBG_SYNC;
    end
    return hs ? UBG_ASYNC_HIGH : UBG_ASYNC_LOW;
  endfunction

  // post divide after the base timer
  function automatic logic [4:0] ubg_post_div(input ubg_rate_mode_t m);
    unique case (m)
      UBG_ASYNC_LOW:  return `UBG_POST_LOW;
      UBG_ASYNC_HIGH: return `UBG_POST_HIGH;
      UBG_SYNC:       return `UBG_POST_SYNC;
      default:        return `UBG_POST_SYNC;
    endcase
  endfunction

  // whole tick period in oscillator cycles
  function automatic logic [15:0] ubg_period(input ubg_rate_mode_t m, input logic [7:0] div);
    logic [15:0] k;
    k = 16'({11'h000, `UBG_PRESCALE} * {11'h000, ubg_post_div(m)});
    return 16'(k * ({8'h00, div} + 16'h0001));
  endfunction

  // byte address of a register index
  function automatic logic [11:0] ubg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

endpackage

// File: ubg_rate_timer.sv
// divider chain: prescale by four, 8-bit period timer, post divide by mode
// assumes clear is held while the port is off and pulsed on any restart
`timescale 1ns/100ps
`default_nettype none
`include "ubg_params.svh"

module ubg_rate_timer import ubg_pkg::*; #(
  parameter int DIV_W = 8
) (
  input  wire logic           i_clk,
  input  wire logic           i_nrst,
  input  wire logic           i_clear,
  input  wire logic [DIV_W-1:0] i_divisor,
  input  wire ubg_rate_mode_t i_mode,
  output logic                o_tick
);

  // refuse widths the period helpers cannot serve
  if (DIV_W < 1 || DIV_W > 8) begin : g_chk
    $error("divisor width must be 1 to 8");
  end

  logic [1:0]       pre_reg, pre_next;
  logic [DIV_W-1:0] tmr_reg, tmr_next;
  logic [3:0]       post_reg, post_next;
  logic             tick_reg, tick_next;
  logic             step, base, fire;
  logic [3:0]       post_lim;

  // next state of the chain; clear wins over counting
  always_comb begin
    post_lim  = 4'(ubg_post_div(i_mode) - 5'h01);
    step      = (pre_reg == 2'(`UBG_PRESCALE - 5'h01));
    base      = step && (tmr_reg == i_divisor);
    fire      = base && (post_reg == post_lim);
    pre_next  = pre_reg + 2'h1;
    tmr_next  = step ? (base ? '0 : tmr_reg + 1'b1) : tmr_reg;
    post_next = base ? (fire ? 4'h0 : post_reg + 4'h1) : post_reg;
    tick_next = fire;
    if (i_clear) begin
      pre_next  = 2'h0;
      tmr_next  = '0;
      post_next = 4'h0;
      tick_next = 1'b0;
    end
  end

  // chain registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pre_reg  <= 2'h0;
      tmr_reg  <= '0;
      post_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      tmr_reg  <= tmr_next;
      post_reg <= post_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;

endmodule
`default_nettype wire

// File: ubg_top.sv
// usart rate generator with its control registers behind an apb slave
// assumes a synchronous apb master on I_MCLK and status inputs from the transceiver
// How it works
// - async, high speed clear: tick rate is oscillator over 64 times divisor plus one
// - async, high speed set: tick rate is oscillator over 16 times divisor plus one
// - sync: rate is oscillator over 4 times divisor plus one; high speed ignored
// - divisor is unsigned 8 bits from its register; all values 0..255 used
// - any divisor write clears the rate timer at once
// - divisor resets to zero on every reset
// - transmit control holds its fields, resets to 0x02, bit 3 reads zero, shift register empty from transceiver
// - receive control holds its fields, resets to zero, framing error, overrun error and ninth bit from receiver
// - rate generator is a free running 8-bit timer set by the divisor
// - ticks only when the port runs as clock master or asynchronous
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ubg_params.svh"

module ubg_top import ubg_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input  wire logic              I_MCLK,
  input  wire logic              I_NRST,
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [ADDR_W-1:0] I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic      [31:0]       O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  input  wire logic              I_SHIFT_REGISTER_EMPTY,
  input  wire logic              I_FRAMING_ERROR_FLAG,
  input  wire logic              I_OVERRUN_ERROR_FLAG,
  input  wire logic              I_RECEIVED_NINTH_BIT,
  output logic                   O_BIT_TICK,
  output logic      [7:0]        O_TRANSMIT_STATUS_CONTROL,
  output logic      [7:0]        O_RECEIVE_STATUS_CONTROL
);

  if (ADDR_W < 12) begin : g_chk
    $error("address width must reach the highest register");
  end

  ubg_tx_ctrl_t tx_reg, tx_next;
  ubg_rx_ctrl_t rx_reg, rx_next;
  logic [7:0]   div_reg, div_next;
  logic [31:0]  prdata_reg, prdata_next;
  logic         pready_reg, pready_next;
  logic         pslverr_reg, pslverr_next;
  logic         setup, access, wr;
  logic         hit_tx, hit_rx, hit_div;
  logic         restart, run, clear;
  logic [7:0]   wbyte;
  ubg_rate_mode_t mode;
  logic         tick;

  // address decode and phase of the apb transfer
  always_comb begin
    hit_rx  = (I_PADDR[11:0] == ubg_addr(`UBG_IDX_RX_CTRL));
    hit_tx  = (I_PADDR[11:0] == ubg_addr(`UBG_IDX_TX_CTRL));
    hit_div = (I_PADDR[11:0] == ubg_addr(`UBG_IDX_DIVISOR));
    setup   = I_PSEL && !I_PENABLE;
    access  = I_PSEL && I_PENABLE && pready_reg;
    wr      = access && I_PWRITE;
    wbyte   = I_PWDATA[7:0];
  end

  // register next values; status bits follow the transceiver each cycle
  always_comb begin
    tx_next = tx_reg;
    rx_next = rx_reg;
    div_next = div_reg;
    restart = 1'b0;
    if (wr && hit_tx) begin
      tx_next = ubg_tx_ctrl_t'(wbyte);
      restart = (wbyte[4] != tx_reg.sync_mode) || (wbyte[2] != tx_reg.high_speed_select);
    end
    if (wr && hit_rx) begin
      rx_next = ubg_rx_ctrl_t'(wbyte);
      restart = wbyte[7] != rx_reg.port_enable;
    end
    if (wr && hit_div) begin
      div_next = wbyte;
      restart  = 1'b1;
    end
    tx_next.unused3              = 1'b0;
    tx_next.shift_register_empty = I_SHIFT_REGISTER_EMPTY;
    rx_next.framing_error_flag   = I_FRAMING_ERROR_FLAG;
    rx_next.overrun_error_flag   = I_OVERRUN_ERROR_FLAG;
    rx_next.received_ninth_bit   = I_RECEIVED_NINTH_BIT;
  end

  // apb answer: ready and read data registered from the setup cycle
  always_comb begin
    pready_next  = setup;
    pslverr_next = setup && !(hit_rx || hit_tx || hit_div);
    prdata_next  = prdata_reg;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      if (!I_PWRITE && hit_rx) begin
        prdata_next = {24'h00_0000, rx_reg};
      end
      if (!I_PWRITE && hit_tx) begin
        prdata_next = {24'h00_0000, tx_reg};
      end
      if (!I_PWRITE && hit_div) begin
        prdata_next = {24'h00_0000, div_reg};
      end
    end
  end

  // register file and bus answer
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_reg      <= ubg_tx_ctrl_t'(`UBG_TX_CTRL_RST);
      rx_reg      <= ubg_rx_ctrl_t'(`UBG_RX_CTRL_RST);
      div_reg     <= `UBG_DIVISOR_RST;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      tx_reg      <= tx_next;
      rx_reg      <= rx_next;
      div_reg     <= div_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // rate generator runs only as master or asynchronous with the port on
  always_comb begin
    mode  = ubg_mode(tx_reg.sync_mode, tx_reg.high_speed_select);
    run   = rx_reg.port_enable && (!tx_reg.sync_mode || tx_reg.clock_source_select);
    clear = restart || !run;
  end

  ubg_rate_timer #(
    .DIV_W (8)
  ) u_timer (
    .i_clk     (I_MCLK),
    .i_nrst    (I_NRST),
    .i_clear   (clear),
    .i_divisor (div_reg),
    .i_mode    (mode),
    .o_tick    (tick)
  );

  assign O_PRDATA                  = prdata_reg;
  assign O_PREADY                  = pready_reg;
  assign O_PSLVERR                 = pslverr_reg;
  assign O_BIT_TICK                = tick;
  assign O_TRANSMIT_STATUS_CONTROL = tx_reg;
  assign O_RECEIVE_STATUS_CONTROL  = rx_reg;

  // helper: cycles since the last tick or clear, for the period checks
  logic [15:0] gap_reg, gap_next;
  logic        fresh_reg, fresh_next;
  logic        div_seen_reg, div_seen_next;
  logic [15:0] want;
  always_comb begin
    gap_next      = clear || tick ? 16'h0000 : gap_reg + 16'h0001;
    fresh_next    = clear ? 1'b1 : (tick ? 1'b0 : fresh_reg);
    div_seen_next = div_seen_reg || (wr && hit_div);
    want          = ubg_period(mode, div_reg) - (fresh_reg ? 16'h0000 : 16'h0001);
  end
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      gap_reg      <= 16'h0000;
      fresh_reg    <= 1'b1;
      div_seen_reg <= 1'b0;
    end else begin
      gap_reg      <= gap_next;
      fresh_reg    <= fresh_next;
      div_seen_reg <= div_seen_next;
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  a_low_period: assert property (tick && mode == UBG_ASYNC_LOW |-> gap_reg == want)
    else $error("async low speed tick period wrong");
  a_high_period: assert property (tick && mode == UBG_ASYNC_HIGH |-> gap_reg == want)
    else $error("async high speed tick period wrong");
  a_sync_period: assert property (tick && mode == UBG_SYNC |-> gap_reg == want)
    else $error("sync tick period wrong");
  a_div_stored: assert property (wr && hit_div |=> div_reg == $past(I_PWDATA[7:0]))
    else $error("divisor write not stored");
  a_div_restart: assert property (wr && hit_div |=> !tick [*4])
    else $error("tick too soon after divisor write");
  a_div_reset: assert property (!div_seen_reg |-> div_reg == 8'h00)
    else $error("divisor not zero after reset");
  a_tx_unused: assert property (O_TRANSMIT_STATUS_CONTROL[3] == 1'b0)
    else $error("unimplemented transmit bit set");
  a_rx_status: assert property (1'b1 |=> O_RECEIVE_STATUS_CONTROL[2:0] ==
      {$past(I_FRAMING_ERROR_FLAG), $past(I_OVERRUN_ERROR_FLAG), $past(I_RECEIVED_NINTH_BIT)})
    else $error("receive status does not follow transceiver");
  a_slave_silent: assert property (!run |=> !tick)
    else $error("tick while not clock master");
  a_mode_restart: assert property (restart ##1 !restart && run |-> !tick [*3])
    else $error("tick too soon after restart");
  a_apb_ready: assert property (setup |=> O_PREADY ##1 !O_PREADY)
    else $error("apb answer not one cycle after setup");

  c_low: cover property (tick && mode == UBG_ASYNC_LOW && !fresh_reg);
  c_high: cover property (tick && mode == UBG_ASYNC_HIGH && !fresh_reg);
  c_sync: cover property (tick && mode == UBG_SYNC && !fresh_reg);
  c_div_write: cover property (wr && hit_div ##[1:300] tick);

endmodule
`default_nettype wire

// File: test_usart_baud_rate_generator.sv
// testbench for the usart rate generator: register access over apb and tick period checks
// assumes the design files and the package are compiled first; the bench drives every port itself
`timescale 1ns/100ps
`default_nettype none

module test_usart_baud_rate_generator;
  // byte addresses are four times the register index
  localparam logic [11:0] ADDR_RX = 12'h060;
  localparam logic [11:0] ADDR_TX = 12'h260;
  localparam logic [11:0] ADDR_DV = 12'h264;

  typedef struct {
    logic [7:0] tx;
    logic [7:0] div;
    int         per;
  } ubg_row_t;

  logic        mclk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sre;
  logic        fe;
  logic        oe;
  logic        r9;
  logic        tick;
  logic [7:0]  txc;
  logic [7:0]  rxc;
  int          miscompares;
  int          num_checks;
  int          n;
  // transmit control, divisor, expected tick period in clocks
  ubg_row_t    rows [6] = '{'{8'h00, 8'h00, 64}, '{8'h00, 8'h02, 192}, '{8'h04, 8'h00, 16},
                            '{8'h04, 8'hFF, 4096}, '{8'h90, 8'h00, 4}, '{8'h94, 8'h03, 16}};

  ubg_top i_dut (
    .I_MCLK                    (mclk),
    .I_NRST                    (nrst),
    .I_PSEL                    (psel),
    .I_PENABLE                 (penable),
    .I_PWRITE                  (pwrite),
    .I_PADDR                   (paddr),
    .I_PWDATA                  (pwdata),
    .O_PRDATA                  (prdata),
    .O_PREADY                  (pready),
    .O_PSLVERR                 (pslverr),
    .I_SHIFT_REGISTER_EMPTY    (sre),
    .I_FRAMING_ERROR_FLAG      (fe),
    .I_OVERRUN_ERROR_FLAG      (oe),
    .I_RECEIVED_NINTH_BIT      (r9),
    .O_BIT_TICK                (tick),
    .O_TRANSMIT_STATUS_CONTROL (txc),
    .O_RECEIVE_STATUS_CONTROL  (rxc)
  );

  // 20 MHz oscillator
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    // look between edges: the registered answer is settled there and stands at the next edge
    @(negedge mclk);
    while (pready !== 1'b1 && k < 16) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 16) begin
      chk("pready", 32'h0000_0001, 32'h0000_0000);
      complete_run();
    end
    r = prdata;
    e = pslverr;
    // the edge that samples pready high ends the access; release only after it
    @(posedge mclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, ex, r);
    chk("pslverr", {31'h0000_0000, ee}, {31'h0000_0000, e});
  endtask

  // clocks until the next tick, bounded; sampled mid-cycle, away from the launch edge
  task automatic wait_tick(input int lim, output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (tick !== 1'b1 && c < lim);
    if (c >= lim) begin
      chk("tick arrival", 32'h0000_0001, 32'h0000_0000);
      complete_run();
    end
  endtask

  // ticks seen over a fixed window
  task automatic count_ticks(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(negedge mclk);
      if (tick === 1'b1) c++;
    end
  endtask

  // first tick after a restart lands one full period later
  task automatic first_tick(input int per);
    int c;
    wait_tick(per + 4, c);
    chk("first tick in range", 32'h0000_0001, {31'h0000_0000, (c >= per && c <= per + 2)});
  endtask

  initial begin
    miscompares = 0;
    num_checks  = 0;
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
    sre = 1'b1; fe = 1'b0; oe = 1'b0; r9 = 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    rdchk("transmit control", ADDR_TX, 32'h0000_0002, 1'b0);
    rdchk("receive control", ADDR_RX, 32'h0000_0000, 1'b0);
    rdchk("divisor", ADDR_DV, 32'h0000_0000, 1'b0);
    $display("test reset values done");
    // rate table: enable the port, then each mode and divisor
    wr(ADDR_RX, 32'h0000_0080);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_TX, {24'h00_0000, rows[i].tx});
      wr(ADDR_DV, {24'h00_0000, rows[i].div});
      first_tick(rows[i].per);
      wait_tick(rows[i].per + 4, n);
      chk("tick period", 32'(rows[i].per), 32'(n));
    end
    $display("test rate table done");
    // divisor write in mid count must not wait for the long period
    wr(ADDR_TX, 32'h0000_0000);
    wr(ADDR_DV, 32'h0000_00FF);
    repeat (100) @(posedge mclk);
    wr(ADDR_DV, 32'h0000_0000);
    first_tick(64);
    repeat (10) @(posedge mclk);
    wr(ADDR_TX, 32'h0000_0004);
    first_tick(16);
    $display("test restart done");
    // sync slave and port off give no ticks
    wr(ADDR_TX, 32'h0000_0010);
    count_ticks(200, n);
    chk("ticks as sync slave", 32'h0000_0000, 32'(n));
    wr(ADDR_TX, 32'h0000_0090);
    wr(ADDR_RX, 32'h0000_0000);
    count_ticks(200, n);
    chk("ticks with port off", 32'h0000_0000, 32'(n));
    $display("test no tick done");
    // read-only bits follow the status inputs, writes to them ignored
    @(posedge mclk);
    fe <= 1'b1;
    r9 <= 1'b1;
    wr(ADDR_TX, 32'h0000_00FF);
    rdchk("transmit control", ADDR_TX, 32'h0000_00F7, 1'b0);
    chk("transmit mirror", 32'h0000_00F7, {24'h00_0000, txc});
    wr(ADDR_RX, 32'h0000_00FF);
    rdchk("receive control", ADDR_RX, 32'h0000_00FD, 1'b0);
    chk("receive mirror", 32'h0000_00FD, {24'h00_0000, rxc});
    wr(ADDR_DV, 32'h0000_005A);
    wr(12'h004, 32'h0000_0011);
    rdchk("unmapped read", 12'h004, 32'h0000_0000, 1'b1);
    rdchk("divisor", ADDR_DV, 32'h0000_005A, 1'b0);
    $display("test register access done");
    // second reset in mid run
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rdchk("divisor after reset", ADDR_DV, 32'h0000_0000, 1'b0);
    rdchk("transmit after reset", ADDR_TX, 32'h0000_0002, 1'b0);
    $display("test second reset done");
    complete_run();
  end
endmodule

`default_nettype wire
